/* hw/bit_branch_exec.sv */
// Purpose: Carry-flag bit operations, branch condition test, jump, call and return
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset
// Notes: Byte slots 0-7 act as general registers, 8-15 as memory bytes
module bit_branch_exec
  import bit_branch_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core status
  output logic busy_o,
  output logic branch_taken_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_WBACK = 3'b100
  } state_e;

  state_e state_q, state_d;
  logic [31:0] cmd_q, cmd_d;
  logic [3:0] flags_q, flags_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] target_q, target_d;
  logic [2:0] sp_q, sp_d;
  logic [7:0] bytes_q [NUM_BYTES];
  logic [15:0] stack_q [STACK_DEPTH];
  logic [7:0] rmw_q;
  logic taken_q, taken_d;
  logic ack_q;
  logic busy_q;
  logic [31:0] rd_q;

  // Bus request decode and byte-lane merge
  // A held strobe is not taken again while its ack is showing
  wire req = cyc_i & stb_i & ~ack_q;
  wire idle = (state_q == ST_IDLE);
  // Writes are refused while a command runs, so operands stay stable
  wire wr = req & we_i & idle;
  // Byte lanes follow sel_i, so a partial write leaves other lanes alone, except the command register, whose unselected lanes load RST_CMD
  wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire wr_cmd = wr & (adr_i == OFS_CMD);
  wire wr_flags = wr & (adr_i == OFS_FLAGS);
  wire wr_pc = wr & (adr_i == OFS_PC);
  wire wr_target = wr & (adr_i == OFS_TARGET);
  wire wr_sp = wr & (adr_i == OFS_SP);
  wire wr_byte = wr & (adr_i[7:6] == OFS_BYTES[7:6]) & sel_i[0];
  wire [3:0] bus_idx = adr_i[5:2];

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~lane_mask) | (dat_i & lane_mask);
  endfunction

  // Command fields
  wire [4:0] op = cmd_q[CMD_OP_LSB +: 5];
  wire [3:0] cond = cmd_q[CMD_COND_LSB +: 4];
  wire [3:0] opnd_idx = cmd_q[CMD_OPND_LSB +: 4];
  wire [2:0] bitreg_idx = cmd_q[CMD_BITREG_LSB +: 3];
  wire inv_op = (op == OP_INV_BIT_XOR_CARRY) | (op == OP_INV_BIT_LOAD_CARRY) |
                (op == OP_INV_CARRY_STORE_BIT);
  wire carry_op = (op == OP_BIT_XOR_CARRY) | (op == OP_INV_BIT_XOR_CARRY) |
                  (op == OP_BIT_LOAD_CARRY) | (op == OP_INV_BIT_LOAD_CARRY);
  wire store_op = (op == OP_CARRY_STORE_BIT) | (op == OP_INV_CARRY_STORE_BIT);
  wire call_op = (op == OP_RELATIVE_SUBROUTINE_CALL) | (op == OP_ABSOLUTE_SUBROUTINE_CALL);
  wire ret_op = (op == OP_SUBROUTINE_RETURN);
  // Inverted forms ignore the register flag and use the immediate position
  wire use_reg_pos = cmd_q[CMD_BITREG_FLAG] & ~inv_op;
  wire [7:0] bitreg_val = bytes_q[{1'b0, bitreg_idx}];

  // Bit position, operand byte and the selected bit
  wire [2:0] bit_pos = use_reg_pos ? bitreg_val[2:0] : cmd_q[CMD_BIT_LSB +: 3];
  wire [7:0] opnd = bytes_q[opnd_idx];
  wire op_bit = opnd[bit_pos];
  wire c_flag = flags_q[FLAG_C];
  wire v_flag = flags_q[FLAG_V];
  wire z_flag = flags_q[FLAG_Z];
  wire n_flag = flags_q[FLAG_N];

  // New carry for the carry-writing bit operations
  logic carry_new;
  always_comb
  begin
    carry_new = c_flag;
    unique case (op)
      OP_BIT_XOR_CARRY: carry_new = c_flag ^ op_bit;
      OP_INV_BIT_XOR_CARRY: carry_new = c_flag ^ ~op_bit;
      OP_BIT_LOAD_CARRY: carry_new = op_bit;
      OP_INV_BIT_LOAD_CARRY: carry_new = ~op_bit;
      default: carry_new = c_flag;
    endcase
  end

  // Byte with one bit replaced by carry or its complement
  wire st_bit = (op == OP_INV_CARRY_STORE_BIT) ? ~c_flag : c_flag;
  wire [7:0] pos_mask = 8'h01 << bit_pos;
  wire [7:0] st_byte = (opnd & ~pos_mask) | ({8{st_bit}} & pos_mask);
  // Slots 8 and up are memory and go through the write-back cycle
  wire st_to_mem = opnd_idx >= FIRST_MEM_IDX;

  // Branch condition evaluation
  logic cond_true;
  always_comb
  begin
    cond_true = 1'b0;
    unique case (cond)
      COND_ALWAYS: cond_true = 1'b1;
      COND_NEVER: cond_true = 1'b0;
      COND_HIGHER: cond_true = ~(c_flag | z_flag);
      COND_LOWER_SAME: cond_true = c_flag | z_flag;
      COND_HIGHER_SAME: cond_true = ~c_flag;
      COND_LOWER: cond_true = c_flag;
      COND_NOT_EQUAL: cond_true = ~z_flag;
      COND_EQUAL: cond_true = z_flag;
      COND_OVERFLOW_CLEAR: cond_true = ~v_flag;
      COND_OVERFLOW_SET: cond_true = v_flag;
      COND_PLUS: cond_true = ~n_flag;
      COND_MINUS: cond_true = n_flag;
      COND_GREATER_EQUAL: cond_true = ~(n_flag ^ v_flag);
      COND_LESS: cond_true = n_flag ^ v_flag;
      COND_GREATER: cond_true = ~(z_flag | (n_flag ^ v_flag));
      COND_LESS_EQUAL: cond_true = z_flag | (n_flag ^ v_flag);
    endcase
  end

  // Program counter targets
  wire exec = (state_q == ST_EXEC);
  wire [15:0] pc_seq = pc_q + PC_STEP;
  // Displacement counts from the address after this command
  wire [15:0] pc_rel = pc_seq + target_q;
  wire [2:0] sp_pop = sp_q - 3'h1;
  logic [15:0] pc_next;
  always_comb
  begin
    // Unknown op codes fall through and only advance the program counter
    pc_next = pc_seq;
    unique case (op)
      OP_BRANCH: pc_next = cond_true ? pc_rel : pc_seq;
      OP_JUMP_UNCONDITIONAL: pc_next = target_q;
      OP_RELATIVE_SUBROUTINE_CALL: pc_next = pc_rel;
      OP_ABSOLUTE_SUBROUTINE_CALL: pc_next = target_q;
      OP_SUBROUTINE_RETURN: pc_next = stack_q[sp_pop];
      default: pc_next = pc_seq;
    endcase
  end

  // Sequencer: memory stores take a second cycle to write back
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: state_d = wr_cmd ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_d = (store_op & st_to_mem) ? ST_WBACK : ST_IDLE;
      ST_WBACK: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Next values of the architectural registers
  wire [31:0] flags_m = merge({28'h0, flags_q});
  wire [31:0] pc_m = merge({16'h0, pc_q});
  wire [31:0] target_m = merge({16'h0, target_q});
  wire [31:0] sp_m = merge({29'h0, sp_q});
  assign cmd_d = wr_cmd ? merge(RST_CMD) : cmd_q;
  // Only carry moves, and only for carry-writing forms
  assign flags_d = wr_flags ? flags_m[3:0] :
                   (exec & carry_op) ? {flags_q[3:1], carry_new} : flags_q;
  assign pc_d = wr_pc ? pc_m[15:0] : exec ? pc_next : pc_q;
  assign target_d = wr_target ? target_m[15:0] : target_q;
  assign sp_d = wr_sp ? sp_m[2:0] :
                (exec & call_op) ? sp_q + 3'h1 :
                (exec & ret_op) ? sp_pop : sp_q;
  // Only a true branch, a jump, a call or a return changes flow
  wire flow_op = (op == OP_JUMP_UNCONDITIONAL) | call_op | ret_op;
  assign taken_d = exec ? ((op == OP_BRANCH) ? cond_true : flow_op) : taken_q;

  // Read data select
  // Reads are served at any time, even while a command runs
  logic [31:0] rd_d;
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (adr_i[7:6] == OFS_BYTES[7:6])
      rd_d = {24'h0, bytes_q[bus_idx]};
    else if (adr_i == OFS_CMD)
      rd_d = cmd_q;
    else if (adr_i == OFS_FLAGS)
      rd_d = {28'h0, flags_q};
    else if (adr_i == OFS_PC)
      rd_d = {16'h0, pc_q};
    else if (adr_i == OFS_TARGET)
      rd_d = {16'h0, target_q};
    else if (adr_i == OFS_SP)
      rd_d = {29'h0, sp_q};
    else if (adr_i == OFS_STATUS)
      rd_d = {27'h0, taken_q, state_q, ~idle};
  end

  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cmd_q <= RST_CMD;
      flags_q <= RST_FLAGS;
      pc_q <= RST_PC;
      target_q <= RST_TARGET;
      sp_q <= RST_SP;
      taken_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      target_q <= target_d;
      sp_q <= sp_d;
      taken_q <= taken_d;
    end
  end

  // Bus answer: one wait state, ack for exactly one cycle
  // Read data is captured at the request edge and shown with ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      rd_q <= rd_d;
    end
  end

  // Busy flag, registered so the port comes straight from a flop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_q <= 1'b0;
    else
      busy_q <= (state_d != ST_IDLE);
  end

  // Register and memory bytes; store result or bus write
  // Bytes and stack have no reset, so software loads them before use
  wire wr_reg_store = exec & store_op & ~st_to_mem;
  wire wr_mem_store = (state_q == ST_WBACK);
  always_ff @(posedge clk_i)
  begin
    // Hold the modified byte one cycle so the write-back sees a stable value
    if (exec)
      rmw_q <= st_byte;
    if (wr_reg_store)
      bytes_q[opnd_idx] <= st_byte;
    else if (wr_mem_store)
      bytes_q[opnd_idx] <= rmw_q;
    else if (wr_byte)
      bytes_q[bus_idx] <= dat_i[7:0];
  end

  // Return-address stack
  // Eight deep; the pointer wraps, so a ninth call overwrites the oldest entry
  always_ff @(posedge clk_i)
  begin
    if (exec & call_op)
      stack_q[sp_q] <= pc_seq;
  end

  assign dat_o = rd_q;
  assign ack_o = ack_q;
  assign busy_o = busy_q;
  assign branch_taken_o = taken_q;

endmodule

/* hw/bit_branch_pkg.sv */
// Purpose: Shared constants for the carry-bit and branch execution slice
// Assumes: 32-bit classic Wishbone register window, 16-bit program counter
// Notes: Offsets are byte addresses, one aligned word per register
package bit_branch_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_TARGET = 8'h0c;
  localparam logic [7:0] OFS_SP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_BYTES = 8'h40;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_COND_LSB = 8;
  localparam int CMD_BIT_LSB = 12;
  localparam int CMD_BITREG_FLAG = 15;
  localparam int CMD_OPND_LSB = 16;
  localparam int CMD_BITREG_LSB = 20;
  // Flag positions in the flag register
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  // Reset values
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_TARGET = 16'h0000;
  localparam logic [2:0] RST_SP = 3'h0;
  localparam logic [31:0] RST_CMD = 32'h0000_0000;
  // Operation codes
  localparam logic [4:0] OP_BIT_XOR_CARRY = 5'h00;
  localparam logic [4:0] OP_INV_BIT_XOR_CARRY = 5'h01;
  localparam logic [4:0] OP_BIT_LOAD_CARRY = 5'h02;
  localparam logic [4:0] OP_INV_BIT_LOAD_CARRY = 5'h03;
  localparam logic [4:0] OP_CARRY_STORE_BIT = 5'h04;
  localparam logic [4:0] OP_INV_CARRY_STORE_BIT = 5'h05;
  localparam logic [4:0] OP_BRANCH = 5'h06;
  localparam logic [4:0] OP_JUMP_UNCONDITIONAL = 5'h07;
  localparam logic [4:0] OP_RELATIVE_SUBROUTINE_CALL = 5'h08;
  localparam logic [4:0] OP_ABSOLUTE_SUBROUTINE_CALL = 5'h09;
  localparam logic [4:0] OP_SUBROUTINE_RETURN = 5'h0a;
  // Branch condition codes
  localparam logic [3:0] COND_ALWAYS = 4'h0;
  localparam logic [3:0] COND_NEVER = 4'h1;
  localparam logic [3:0] COND_HIGHER = 4'h2;
  localparam logic [3:0] COND_LOWER_SAME = 4'h3;
  localparam logic [3:0] COND_HIGHER_SAME = 4'h4;
  localparam logic [3:0] COND_LOWER = 4'h5;
  localparam logic [3:0] COND_NOT_EQUAL = 4'h6;
  localparam logic [3:0] COND_EQUAL = 4'h7;
  localparam logic [3:0] COND_OVERFLOW_CLEAR = 4'h8;
  localparam logic [3:0] COND_OVERFLOW_SET = 4'h9;
  localparam logic [3:0] COND_PLUS = 4'ha;
  localparam logic [3:0] COND_MINUS = 4'hb;
  localparam logic [3:0] COND_GREATER_EQUAL = 4'hc;
  localparam logic [3:0] COND_LESS = 4'hd;
  localparam logic [3:0] COND_GREATER = 4'he;
  localparam logic [3:0] COND_LESS_EQUAL = 4'hf;
  // Storage sizes and step
  localparam int NUM_BYTES = 16;
  localparam logic [3:0] FIRST_MEM_IDX = 4'h8;
  localparam int STACK_DEPTH = 8;
  localparam logic [15:0] PC_STEP = 16'h0002;
endpackage

/* tb/bit_branch_exec_assertions.sv */
// Purpose: Port-level checks for the carry-bit and branch slice
// Assumes: Commands are written as whole words while the slice is idle
// Notes: Results show two sampled edges after the command write
module bit_branch_exec_assertions
  import bit_branch_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and status
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic busy_o,
  input wire logic branch_taken_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Accepted command write and its fields
  wire go = cyc_i & stb_i & we_i & ~ack_o & ~busy_o & (adr_i == OFS_CMD) & (sel_i == 4'hf);
  wire [4:0] op = dat_i[4:0];
  wire [3:0] cnd = dat_i[11:8];
  wire mem = dat_i[19];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_jump_taken: assert property (go && op == OP_JUMP_UNCONDITIONAL |-> ##2 branch_taken_o)
    else $error("jump left flow unchanged");
  a_bitop_no_flow: assert property (go && op <= OP_INV_BIT_LOAD_CARRY |-> ##2 !branch_taken_o)
    else $error("carry bit op changed flow");
  a_store_no_flow: assert property (go && (op == 5'h04 || op == 5'h05) |-> ##2 !branch_taken_o)
    else $error("store changed flow");
  a_branch_always: assert property (go && op == OP_BRANCH && cnd == COND_ALWAYS |-> ##2 branch_taken_o)
    else $error("always branch not taken");
  a_branch_never: assert property (go && op == OP_BRANCH && cnd == COND_NEVER |-> ##2 !branch_taken_o)
    else $error("never branch taken");
  a_call_taken: assert property (go && (op == 5'h08 || op == 5'h09) |-> ##2 branch_taken_o)
    else $error("call left flow unchanged");
  a_return_taken: assert property (go && op == OP_SUBROUTINE_RETURN |-> ##2 branch_taken_o)
    else $error("return left flow unchanged");
  a_reg_store_len: assert property (go && (op == 5'h04 || op == 5'h05) && !mem |=> busy_o ##1 !busy_o)
    else $error("register store busy length wrong");
  a_mem_store_len: assert property (go && (op == 5'h04 || op == 5'h05) && mem |=> busy_o [*2] ##1 !busy_o)
    else $error("memory store busy length wrong");
  c_jump: cover property (go && op == OP_JUMP_UNCONDITIONAL);
  c_mem_store: cover property (go && op == OP_CARRY_STORE_BIT && mem);
  c_return: cover property (go && op == OP_SUBROUTINE_RETURN);
endmodule

bind bit_branch_exec bit_branch_exec_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .busy_o(busy_o), .branch_taken_o(branch_taken_o));

/* tb/tb.sv */
// Purpose: Self-checking bench for the carry-bit and branch slice
// Assumes: Commands finish within three cycles of their write
// Notes: Byte slots are preset before any bit operation uses them
module tb
  import bit_branch_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o, q;
  logic ack_o, busy_o, branch_taken_o;
  int num_errors = 0, checks = 0;
  // Bit op steps: command, flags in, flags out, slot, byte after
  logic [31:0] bc [8] = '{32'h0002_1000, 32'h0002_0001, 32'h0032_8001, 32'h0032_8002,
    32'h0002_1003, 32'h0002_0004, 32'h0002_1005, 32'h0009_7004};
  logic [3:0] bfi [8] = '{4'he, 4'hf, 4'he, 4'he, 4'hf, 4'hf, 4'hf, 4'h1};
  logic [3:0] bfe [8] = '{4'hf, 4'he, 4'hf, 4'hf, 4'he, 4'hf, 4'hf, 4'h1};
  logic [3:0] bs [8] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h9};
  logic [7:0] bb [8] = '{8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5b, 8'h59, 8'hb5};
  // Flow steps: target, op, pc after, stack pointer after
  logic [15:0] ft [5] = '{16'h1234, 16'h0040, 16'h3000, 16'h0000, 16'h0000};
  logic [4:0] fo [5] = '{5'h07, 5'h08, 5'h09, 5'h0a, 5'h0a};
  logic [15:0] fp [5] = '{16'h1234, 16'h1276, 16'h3000, 16'h1278, 16'h1236};
  logic [2:0] fs [5] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h0};
  logic [7:0] ra [5] = '{OFS_FLAGS, OFS_PC, OFS_TARGET, OFS_SP, 8'h20};

  always #2 clk_i = ~clk_i;

  bit_branch_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o),
    .branch_taken_o(branch_taken_o));

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One classic bus cycle, held until ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {1'b1, 1'b1, w, a, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    if (n >= 20)
    begin
      num_errors++;
      $display("ERROR %0t no ack within bound", $time);
      stop_test();
    end
  endtask

  // Command write, then let the longest command finish
  task automatic cmd(input logic [31:0] c);
    xfer(1'b1, OFS_CMD, c);
    chk({31'h0, busy_o}, 32'h1);
    repeat (3) @(posedge clk_i);
    chk({31'h0, busy_o}, 32'h0);
  endtask

  // Expected branch outcome from condition code and flags
  function automatic logic ct(input logic [3:0] c, input logic [3:0] f);
    logic [7:0] x;
    x = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
    return c[0] ? x[c[3:1]] : !x[c[3:1]];
  endfunction

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b0, ra[i], 32'h0);
      chk(q, 32'h0);
    end
    xfer(1'b1, OFS_BYTES + 8'h08, 32'h5a);
    xfer(1'b1, OFS_BYTES + 8'h0c, 32'h01);
    xfer(1'b1, OFS_BYTES + 8'h24, 32'h35);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, OFS_FLAGS, {28'h0, bfi[i]});
      cmd(bc[i]);
      xfer(1'b0, OFS_FLAGS, 32'h0);
      chk(q & 32'hf, {28'h0, bfe[i]});
      xfer(1'b0, OFS_BYTES + {2'b00, bs[i], 2'b00}, 32'h0);
      chk(q & 32'hff, {24'h0, bb[i]});
      chk({31'h0, branch_taken_o}, 32'h0);
    end
    xfer(1'b1, OFS_TARGET, 32'h0010);
    for (int c = 0; c < 16; c++)
      for (int f = 0; f < 16; f++)
      begin
        xfer(1'b1, OFS_FLAGS, f);
        xfer(1'b1, OFS_PC, 32'h0100);
        cmd({20'h0, c[3:0], 8'h06});
        xfer(1'b0, OFS_PC, 32'h0);
        chk(q & 32'hffff, ct(c[3:0], f[3:0]) ? 32'h0112 : 32'h0102);
        chk({31'h0, branch_taken_o}, {31'h0, ct(c[3:0], f[3:0])});
      end
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, OFS_TARGET, {16'h0, ft[i]});
      cmd({27'h0, fo[i]});
      xfer(1'b0, OFS_PC, 32'h0);
      chk(q & 32'hffff, {16'h0, fp[i]});
      xfer(1'b0, OFS_SP, 32'h0);
      chk(q & 32'h7, {29'h0, fs[i]});
      chk({31'h0, branch_taken_o}, 32'h1);
    end
    cmd(32'h0000_000b);
    xfer(1'b0, OFS_PC, 32'h0);
    chk(q & 32'hffff, 32'h1238);
    chk({31'h0, branch_taken_o}, 32'h0);
    stop_test();
  end
endmodule
